/* pkg/bmc_regs.vh */
// Register offsets, field positions, reset values and timing counts of the monitor control block.
`ifndef BMC_REGS_VH
`define BMC_REGS_VH

// Register indices and their AHB byte addresses (index times four).
`define BMC_IDX_SELF_TEST        8'h0C
`define BMC_IDX_CFG_HIGH         8'h0D
`define BMC_IDX_CFG_LOW          8'h0E
`define BMC_IDX_STATUS           8'h20
`define BMC_ADDR_SELF_TEST       12'h030
`define BMC_ADDR_CFG_HIGH        12'h034
`define BMC_ADDR_CFG_LOW         12'h038
`define BMC_ADDR_STATUS          12'h080

// Field positions within the 16-bit configuration word.
`define BMC_F_INSEL_HI           15
`define BMC_F_INSEL_LO           14
`define BMC_F_RDSEL_HI           13
`define BMC_F_RDSEL_LO           12
`define BMC_F_TRIG_CS            11
`define BMC_F_AVG_HI             10
`define BMC_F_AVG_LO             9
`define BMC_F_SW_PD              8
`define BMC_F_SW_RST             7
`define BMC_F_ACQ_HI             6
`define BMC_F_ACQ_LO             5
`define BMC_F_RSVD               4
`define BMC_F_THERM              3
`define BMC_F_LOCK               2
`define BMC_F_INCR               1
`define BMC_F_CHAIN_RB           0

// Reset values of the two configuration bytes.
`define BMC_RST_CFG_HIGH         8'h00
`define BMC_RST_CFG_LOW          8'h03

// Acquisition times in nanoseconds and the system clock period.
`define BMC_CLK_PERIOD_NS        20
`define BMC_ACQ0_NS              400
`define BMC_ACQ1_NS              800
`define BMC_ACQ2_NS              1200
`define BMC_ACQ3_NS              1600
`define BMC_ACQ0_CYC             7'd20
`define BMC_ACQ1_CYC             7'd40
`define BMC_ACQ2_CYC             7'd60
`define BMC_ACQ3_CYC             7'd80

`endif

/* hw/bmc_pin_sync.v */
// Three-stage pin synchroniser with a filtered level and edge pulses.
`timescale 1ns/10ps
`default_nettype none

module bmc_pin_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input  wire hclk,         // System clock.
    input  wire hresetn,      // Asynchronous reset, active low.
    input  wire pin_in,       // Raw pin from outside the clock domain.
    output reg  level_reg,    // Filtered level.
    output reg  rise_reg,     // One-cycle pulse on an accepted rising change.
    output reg  fall_reg      // One-cycle pulse on an accepted falling change.
);

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // The first stage feeds only the second; a change counts once stages two and three agree.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_reg    <= RESET_LEVEL;
            s2_reg    <= RESET_LEVEL;
            s3_reg    <= RESET_LEVEL;
            level_reg <= RESET_LEVEL;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
        end
        else
        begin
            s1_reg   <= pin_in;
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
            if ((s2_reg == s3_reg) && (s3_reg != level_reg))
            begin
                level_reg <= s3_reg;
                rise_reg  <= s3_reg;
                fall_reg  <= ~s3_reg;
            end
        end
    end

endmodule // bmc_pin_sync

`default_nettype wire

/* hw/bmc_monitor_control.v */
// Configuration and self-test result registers of the battery monitor, behind an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_regs.vh"

module bmc_monitor_control #(
    parameter ADDR_W = 5       // Width of the daisy-chain device address.
) (
    input  wire              hclk,                  // System clock, 50 MHz.
    input  wire              hresetn,               // Asynchronous reset, active low.
    input  wire              hsel,                  // AHB slave select.
    input  wire [31:0]       haddr,                 // AHB address.
    input  wire [1:0]        htrans,                // AHB transfer type.
    input  wire              hwrite,                // AHB write when high.
    input  wire [2:0]        hsize,                 // AHB transfer size.
    input  wire [31:0]       hwdata,                // AHB write data.
    input  wire              hready,                // AHB bus ready.
    output reg  [31:0]       hrdata,                // AHB read data.
    output wire              hreadyout,             // AHB slave ready.
    output wire              hresp,                 // AHB response, always OKAY.
    input  wire              conversion_start_pin_n, // Conversion start pin, active low.
    input  wire              power_down_pin_n,      // Power-down pin, active low.
    input  wire              chip_select_n,         // Serial chip select, active low.
    input  wire              self_test_valid,       // Pulse: new self-test result.
    input  wire [11:0]       self_test_data,        // Self-test conversion result.
    input  wire              cmd_addr_valid,        // Pulse: write command address seen.
    input  wire [ADDR_W-1:0] cmd_addr,              // Device address from the command.
    output reg               conv_start,            // Pulse: start a conversion.
    output reg  [1:0]        conv_input_sel,        // Inputs to convert.
    output reg  [1:0]        readback_sel,          // Results to read back.
    output reg  [1:0]        avg_sel,               // Averaging code.
    output reg  [6:0]        acq_cycles,            // Acquisition time in clock cycles.
    output reg               thermistor_termination_pin, // Termination resistor enable.
    output reg               powered_down,          // Device is powered down.
    output reg               soft_reset_active,     // Software reset held.
    output reg               chain_readback_en,     // Daisy-chain readback enabled.
    output reg  [ADDR_W-1:0] crc_addr,              // Address used for CRC.
    output reg               fwd_addr_valid,        // Pulse: forwarded address ready.
    output reg  [ADDR_W-1:0] fwd_addr               // Address passed up the chain.
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam ST_IDLE  = 3'b001;
    localparam ST_WRITE = 3'b010;
    localparam ST_READ  = 3'b100;

    reg  [2:0]        state_reg;
    reg  [2:0]        state_next;
    reg  [11:0]       addr_reg;
    reg  [7:0]        cfg_high_reg;        // Bits 15:8 of the configuration word.
    reg  [7:0]        cfg_low_reg;         // Bits 7:0 of the configuration word.
    reg  [11:0]       self_test_reg;
    reg  [ADDR_W-1:0] locked_addr_reg;
    reg               pd_hw_reg;
    wire [15:0]       cfg_word;
    wire              conversion_start_pin_level;
    wire              conversion_start_pin_fall;
    wire              pd_level;
    wire              pd_fall;
    wire              pd_rise;
    wire              cs_level;
    wire              cs_rise;
    wire              addr_phase;
    wire              wr_high;
    wire              wr_low;
    wire              cs_launch;
    wire              pin_launch;
    wire              pd_any;

    // Byte address of a word register from its index.
    function [11:0] idx_to_addr;
        input [7:0] idx;
        begin
            idx_to_addr = {2'b00, idx, 2'b00};
        end
    endfunction

    // Acquisition time code to clock cycles.
    function [6:0] acq_decode;
        input [1:0] code;
        begin
            case (code)
                2'b00:   acq_decode = `BMC_ACQ0_CYC;
                2'b01:   acq_decode = `BMC_ACQ1_CYC;
                2'b10:   acq_decode = `BMC_ACQ2_CYC;
                default: acq_decode = `BMC_ACQ3_CYC;
            endcase
        end
    endfunction

    assign cfg_word = {cfg_high_reg, cfg_low_reg};

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    bmc_pin_sync #(.RESET_LEVEL(1'b1)) u_conversion_start_pin_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (conversion_start_pin_n),
        .level_reg (conversion_start_pin_level),
        .rise_reg  (),
        .fall_reg  (conversion_start_pin_fall)
    );

    bmc_pin_sync #(.RESET_LEVEL(1'b1)) u_pd_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (power_down_pin_n),
        .level_reg (pd_level),
        .rise_reg  (pd_rise),
        .fall_reg  (pd_fall)
    );

    bmc_pin_sync #(.RESET_LEVEL(1'b1)) u_cs_sync (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .pin_in    (chip_select_n),
        .level_reg (cs_level),
        .rise_reg  (cs_rise),
        .fall_reg  ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes take no wait state, reads take one so hrdata comes from a flop.

    assign addr_phase = hsel & hready & htrans[1];
    assign hresp      = 1'b0;
    assign hreadyout  = (state_reg != ST_READ);
    assign wr_high    = (state_reg == ST_WRITE) && (addr_reg == idx_to_addr(`BMC_IDX_CFG_HIGH));
    assign wr_low     = (state_reg == ST_WRITE) && (addr_reg == idx_to_addr(`BMC_IDX_CFG_LOW));

    // Next state of the transfer tracker.
    always @*
    begin
        state_next = ST_IDLE;
        case (state_reg)
            ST_IDLE, ST_WRITE:
            begin
                if (addr_phase)
                    state_next = hwrite ? ST_WRITE : ST_READ;
            end
            ST_READ:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Transfer state, captured address and registered read data.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= ST_IDLE;
            addr_reg  <= 12'h000;
            hrdata    <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            if (addr_phase)
                addr_reg <= haddr[11:0];
            if (state_reg == ST_READ)
            begin
                // Unmapped addresses read as zero; narrow registers sit in the low bits.
                case (addr_reg)
                    `BMC_ADDR_SELF_TEST: hrdata <= {20'h0_0000, self_test_reg};
                    `BMC_ADDR_CFG_HIGH:  hrdata <= {24'h00_0000, cfg_high_reg};
                    `BMC_ADDR_CFG_LOW:   hrdata <= {24'h00_0000, cfg_low_reg};
                    `BMC_ADDR_STATUS:    hrdata <= {{(27 - ADDR_W){1'b0}}, locked_addr_reg,
                                                    pd_hw_reg, ~pd_level, ~cs_level, ~conversion_start_pin_level,
                                                    powered_down};
                    default:             hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion start sources.

    assign cs_launch  = cfg_high_reg[`BMC_F_TRIG_CS - 8] & cs_rise;
    assign pin_launch = ~cfg_high_reg[`BMC_F_TRIG_CS - 8] & conversion_start_pin_fall;
    assign pd_any     = cfg_high_reg[`BMC_F_SW_PD - 8] | pd_hw_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration high byte; a held software reset forces it to its default.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_high_reg <= `BMC_RST_CFG_HIGH;
        end
        else if (cfg_low_reg[`BMC_F_SW_RST])
        begin
            cfg_high_reg <= `BMC_RST_CFG_HIGH;
        end
        else if (wr_high)
        begin
            // A software write landing with a chip-select launch wins, so the new trigger setting holds.
            cfg_high_reg <= hwdata[7:0];
        end
        else if (cs_launch && !pd_any)
        begin
            cfg_high_reg[`BMC_F_TRIG_CS - 8] <= 1'b0;
        end
    end

    // Configuration low byte; untouched by software reset so the host can release it.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cfg_low_reg <= `BMC_RST_CFG_LOW;
        else if (wr_low)
            cfg_low_reg <= hwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-test result capture.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            self_test_reg <= 12'h000;
        else if (self_test_valid)
            self_test_reg <= self_test_data;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Hardware power-down: a falling pin edge enters, a rising edge leaves; software power-down clears it and masks both edges.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pd_hw_reg <= 1'b0;
        else if (cfg_high_reg[`BMC_F_SW_PD - 8])
            pd_hw_reg <= 1'b0;
        else if (pd_fall)
            pd_hw_reg <= 1'b1;
        else if (pd_rise)
            pd_hw_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered configuration outputs and the conversion start pulse.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conv_start                 <= 1'b0;
            conv_input_sel             <= 2'b00;
            readback_sel               <= 2'b00;
            avg_sel                    <= 2'b00;
            acq_cycles                 <= acq_decode(2'b00);
            thermistor_termination_pin <= 1'b0;
            powered_down               <= 1'b0;
            soft_reset_active          <= 1'b0;
            chain_readback_en          <= 1'b1;
        end
        else
        begin
            // Starts are dropped while powered down or held in reset, since nothing could convert.
            conv_start                 <= (cs_launch | pin_launch) & ~pd_any
                                          & ~cfg_low_reg[`BMC_F_SW_RST];
            conv_input_sel             <= cfg_word[`BMC_F_INSEL_HI:`BMC_F_INSEL_LO];
            readback_sel               <= cfg_word[`BMC_F_RDSEL_HI:`BMC_F_RDSEL_LO];
            avg_sel                    <= cfg_word[`BMC_F_AVG_HI:`BMC_F_AVG_LO];
            acq_cycles                 <= acq_decode(cfg_word[`BMC_F_ACQ_HI:`BMC_F_ACQ_LO]);
            thermistor_termination_pin <= cfg_word[`BMC_F_THERM];
            powered_down               <= pd_any;
            soft_reset_active          <= cfg_word[`BMC_F_SW_RST];
            chain_readback_en          <= cfg_word[`BMC_F_CHAIN_RB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Device address locking, CRC address and forwarding up the chain.

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            locked_addr_reg <= {ADDR_W{1'b0}};
            crc_addr        <= {ADDR_W{1'b0}};
            fwd_addr_valid  <= 1'b0;
            fwd_addr        <= {ADDR_W{1'b0}};
        end
        else
        begin
            if (cmd_addr_valid && cfg_word[`BMC_F_LOCK])
                locked_addr_reg <= cmd_addr;
            // Unlocked parts compute CRC with address zero.
            crc_addr       <= cfg_word[`BMC_F_LOCK] ? locked_addr_reg : {ADDR_W{1'b0}};
            fwd_addr_valid <= cmd_addr_valid;
            if (cmd_addr_valid)
            begin
                // The increment wraps at the top of the address range.
                fwd_addr <= cfg_word[`BMC_F_INCR] ? cmd_addr + {{(ADDR_W - 1){1'b0}}, 1'b1}
                                                  : cmd_addr;
            end
        end
    end

endmodule // bmc_monitor_control

`default_nettype wire

/* bench/bmc_monitor_control_sva.sv */
// Assertion checker bound to the monitor control block's ports.
`timescale 1ns/10ps
`default_nettype none
module bmc_monitor_control_sva #(
    parameter ADDR_W = 5
) (
    input wire logic              hclk, // Clock.
    input wire logic              hresetn, // Reset, active low.
    input wire logic              hsel, // Select.
    input wire logic [1:0]        htrans, // Transfer type.
    input wire logic              hwrite, // Write.
    input wire logic              hready, // Bus ready.
    input wire logic [31:0]       hrdata, // Read data.
    input wire logic              hreadyout, // Slave ready.
    input wire logic              hresp, // Response.
    input wire logic              conversion_start_pin_n, // Start pin.
    input wire logic              chip_select_n, // Chip select.
    input wire logic              cmd_addr_valid, // Address pulse.
    input wire logic [ADDR_W-1:0] cmd_addr, // Command address.
    input wire logic              conv_start, // Start pulse.
    input wire logic [1:0]        conv_input_sel, // Input select.
    input wire logic [6:0]        acq_cycles, // Acquisition cycles.
    input wire logic              chain_readback_en, // Chain readback.
    input wire logic              fwd_addr_valid, // Forward pulse.
    input wire logic [ADDR_W-1:0] fwd_addr // Forwarded address.
);
    logic       prev_cs_n;
    logic       prev_cnv_n;
    logic [3:0] since_edge;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since a raw start edge; a start with no recent cause is a fault.
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_cs_n  <= 1'b1;
            prev_cnv_n <= 1'b1;
            since_edge <= 4'hF;
        end
        else
        begin
            prev_cs_n  <= chip_select_n;
            prev_cnv_n <= conversion_start_pin_n;
            if ((!prev_cs_n && chip_select_n) || (prev_cnv_n && !conversion_start_pin_n))
                since_edge <= 4'h0;
            else if (since_edge != 4'hF)
                since_edge <= since_edge + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (hresp == 1'b0) else $error("response not OKAY");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed outside a read");
    a_reset_values: assert property ($rose(hresetn) |-> chain_readback_en && acq_cycles == 7'd20
        && conv_input_sel == 2'b00) else $error("reset defaults wrong");
    a_start_single: assert property (conv_start |=> !conv_start) else $error("start pulse too long");
    a_start_cause: assert property (conv_start |-> since_edge >= 4'd2 && since_edge <= 4'd8)
        else $error("start without pin edge");
    a_acq_legal: assert property (acq_cycles inside {7'd20, 7'd40, 7'd60, 7'd80})
        else $error("acquisition count illegal");
    a_fwd_pulse: assert property (cmd_addr_valid |=> fwd_addr_valid) else $error("address not forwarded");
    a_fwd_value: assert property (fwd_addr_valid |-> $past(cmd_addr_valid) && (fwd_addr == $past(cmd_addr)
        || fwd_addr == $past(cmd_addr) + 1'b1)) else $error("forwarded address wrong");
endmodule // bmc_monitor_control_sva

bind bmc_monitor_control bmc_monitor_control_sva #(.ADDR_W(ADDR_W)) u_sva (.*);
`default_nettype wire

/* bench/bmc_link_host.sv */
// Behavioural model of the serial host driving the monitor's pins.
`timescale 1ns/10ps
`default_nettype none
module bmc_link_host (
    output logic chip_select_n,          // Serial chip select, idles high.
    output logic conversion_start_pin_n, // Start pin, idles high.
    output logic power_down_pin_n,       // Power-down pin, idles high.
    output logic link_clk                // Link clock, still outside frames.
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pins idle high; the 7 ns offset keeps edges off the clock edge.
    initial
    begin
        chip_select_n          = 1'b1;
        conversion_start_pin_n = 1'b1;
        power_down_pin_n       = 1'b1;
        link_clk               = 1'b0;
    end

    // One frame of eight link clocks; the closing rise of select may launch a start.
    task automatic cs_frame;
        #7;
        chip_select_n = 1'b0;
        repeat (8)
        begin
            #80 link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
        chip_select_n = 1'b1;
    endtask

    // Start pin held low two link periods so the synchroniser surely sees it.
    task automatic conversion_start_pin_pulse;
        #7;
        conversion_start_pin_n = 1'b0;
        #320 conversion_start_pin_n = 1'b1;
    endtask

    // Power-down pin level; the falling edge requests power-down.
    task automatic pd_level(input logic v);
        #7;
        power_down_pin_n = v;
    endtask
endmodule // bmc_link_host
`default_nettype wire

/* bench/bmc_monitor_control_tb.sv */
// Self-checking testbench of the monitor control block.
`timescale 1ns/10ps
`default_nettype none
`include "bmc_regs.vh"
module bmc_monitor_control_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, cnv_n, pd_n, cs_n, link_clk;
    logic [31:0] haddr, hwdata, hrdata, rd_exp, rd_mask;
    logic [1:0]  htrans, insel, rdsel, avg;
    logic [2:0]  hsize;
    logic        st_valid, ca_valid, conv_start, therm, pwd, srst, chain_en, fwd_valid;
    logic [11:0] st_data;
    logic [4:0]  ca, crc, fwd, a;
    logic [6:0]  acq;
    logic [7:0]  lo;
    logic [31:0] exp_q[$], mask_q[$];
    logic        rd_dp = 1'b0;
    int          fail_count = 0, checked = 0, conv_seen = 0, conv_exp = 0, cycles = 0;

    assign hready = hreadyout;

    bmc_monitor_control #(.ADDR_W(5)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conversion_start_pin_n(cnv_n), .power_down_pin_n(pd_n),
        .chip_select_n(cs_n), .self_test_valid(st_valid), .self_test_data(st_data), .cmd_addr_valid(ca_valid),
        .cmd_addr(ca), .conv_start(conv_start), .conv_input_sel(insel), .readback_sel(rdsel), .avg_sel(avg),
        .acq_cycles(acq), .thermistor_termination_pin(therm), .powered_down(pwd), .soft_reset_active(srst),
        .chain_readback_en(chain_en), .crc_addr(crc), .fwd_addr_valid(fwd_valid), .fwd_addr(fwd));

    bmc_link_host host (.chip_select_n(cs_n), .conversion_start_pin_n(cnv_n), .power_down_pin_n(pd_n),
        .link_clk(link_clk));

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] got, exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One single transfer; the master waits on ready, never on a fixed count.
    task automatic bus(input logic [11:0] ad, input logic wr, input logic [31:0] d);
        haddr  <= {20'h0_0000, ad};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] exp, input logic [31:0] m);
        exp_q.push_back(exp);
        mask_q.push_back(m);
        bus(ad, 1'b0, 32'h0000_0000);
    endtask

    task automatic wr8(input logic [11:0] ad, input logic [7:0] d);
        bus(ad, 1'b1, {24'h00_0000, d});
        repeat (3) @(posedge hclk);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Read results are compared against the oldest note when the data phase ends.
    always @(posedge hclk)
    begin
        if (rd_dp && hready === 1'b1)
        begin
            rd_exp  = exp_q.pop_front();
            rd_mask = mask_q.pop_front();
            compare(hrdata & rd_mask, rd_exp, "read");
        end
        if (hready === 1'b1)
            rd_dp = hsel && htrans[1] && !hwrite;
        if (conv_start === 1'b1)
            conv_seen++;
        cycles++;
        if (cycles == 10000)
        begin
            fail_count++;
            $display("ERROR %0t timeout", $time);
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {hresetn, hwrite, st_valid, ca_valid, htrans, haddr, hwdata, st_data, ca} = '0;
        hsel  = 1'b1;
        hsize = 3'b010;
        void'($urandom(32'he410));
        wait_cyc(6);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`BMC_ADDR_CFG_HIGH, 32'h0000_0000, 32'h0000_00FF);
        rd(`BMC_ADDR_CFG_LOW, 32'h0000_0003, 32'h0000_00FF);
        compare({insel, rdsel, avg, therm, pwd, srst, chain_en, acq}, {9'h001, 7'd20}, "defaults");
        $display("test defaults done");
        for (int k = 0; k < 4; k++)
        begin
            lo = {1'b0, 2'(k), 1'b1, (k == 3) & 1'($urandom), 2'b01, 1'($urandom)};
            wr8(`BMC_ADDR_CFG_LOW, lo);
            rd(`BMC_ADDR_CFG_LOW, {24'h00_0000, lo}, 32'h0000_00FF);
            compare(acq, (k + 1) * `BMC_ACQ0_NS / `BMC_CLK_PERIOD_NS, "acq");
            compare({therm, chain_en}, {lo[3], lo[0]}, "low bits");
            wr8(`BMC_ADDR_CFG_HIGH, {2'(k), 2'(k), 1'b0, 2'(k), 1'b0});
            compare({insel, rdsel, avg}, {2'(k), 2'(k), 2'(k)}, "high fields");
        end
        $display("test fields done");
        st_data  <= 12'($urandom);
        st_valid <= 1'b1;
        @(posedge hclk);
        st_valid <= 1'b0;
        bus(`BMC_ADDR_SELF_TEST, 1'b1, ~{20'h0_0000, st_data});
        rd(`BMC_ADDR_SELF_TEST, {20'h0_0000, st_data}, 32'h0000_0FFF);
        rd(12'h0FC, 32'h0000_0000, 32'hFFFF_FFFF);
        $display("test self-test done");
        for (int lock = 1; lock >= 0; lock--)
        begin
            wr8(`BMC_ADDR_CFG_LOW, {5'b00010, 1'(lock), 1'(lock), 1'b1});
            a = lock ? 5'h1F : 5'($urandom);
            ca       <= a;
            ca_valid <= 1'b1;
            @(posedge hclk);
            ca_valid <= 1'b0;
            @(posedge hclk);
            compare({fwd_valid, fwd}, {1'b1, a + 5'(lock)}, "forward");
            wait_cyc(2);
            compare(crc, lock ? a : 5'h00, "crc address");
        end
        $display("test address done");
        wr8(`BMC_ADDR_CFG_HIGH, 8'h00);
        host.conversion_start_pin_pulse();
        wait_cyc(12);
        conv_exp++;
        compare(conv_seen, conv_exp, "pin start");
        host.cs_frame();
        wait_cyc(12);
        compare(conv_seen, conv_exp, "select ignored");
        wr8(`BMC_ADDR_CFG_HIGH, 8'h08);
        host.cs_frame();
        wait_cyc(12);
        conv_exp++;
        compare(conv_seen, conv_exp, "select start");
        rd(`BMC_ADDR_CFG_HIGH, 32'h0000_0000, 32'h0000_00FF);
        $display("test start done");
        wr8(`BMC_ADDR_CFG_HIGH, 8'h01);
        compare(pwd, 32'h0000_0001, "soft power-down");
        host.conversion_start_pin_pulse();
        wait_cyc(12);
        compare(conv_seen, conv_exp, "start while down");
        wr8(`BMC_ADDR_CFG_HIGH, 8'h00);
        host.pd_level(1'b0);
        wait_cyc(8);
        compare(pwd, 32'h0000_0001, "pin power-down");
        host.pd_level(1'b1);
        wait_cyc(8);
        compare(pwd, 32'h0000_0000, "power up");
        $display("test power-down done");
        wr8(`BMC_ADDR_CFG_HIGH, 8'h52);
        wr8(`BMC_ADDR_CFG_LOW, 8'hF3);
        compare({srst, insel, rdsel, avg}, 32'h0000_0040, "reset held");
        bus(`BMC_ADDR_CFG_HIGH, 1'b1, 32'h0000_0052);
        rd(`BMC_ADDR_CFG_HIGH, 32'h0000_0000, 32'h0000_00FF);
        rd(`BMC_ADDR_CFG_LOW, 32'h0000_00F3, 32'h0000_00FF);
        wr8(`BMC_ADDR_CFG_LOW, 8'h73);
        compare({srst, insel, rdsel, avg, acq}, {7'h00, 7'd80}, "reset released");
        $display("test soft reset done");
        wait_cyc(2);
        tally_and_finish();
    end
endmodule // bmc_monitor_control_tb
`default_nettype wire
